// ===== dds_consts.svh
`ifndef DDS_CONSTS_SVH
`define DDS_CONSTS_SVH

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define DDS_FRAME_BITS   24
`define DDS_CMD_MSB      23
`define DDS_CMD_LSB      20
`define DDS_SEL_B_POS    19
`define DDS_SEL_A_POS    16
`define DDS_DATA_MSB     15
`define DDS_CHAIN_POS    0
`define DDS_PWR_B_LSB    6
`define DDS_PWR_A_LSB    0

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define DDS_CMD_WRITE_IN  4'h1
`define DDS_CMD_UPDATE    4'h2
`define DDS_CMD_WRITE_UPD 4'h3
`define DDS_CMD_POWER     4'h4
`define DDS_CMD_CHAIN     4'h8
`define DDS_CMD_READBACK  4'h9

// ----------------------------------------------------------------
// Power modes, readback placement, counts, reset values
// ----------------------------------------------------------------
`define DDS_PWR_NORMAL   2'h0
`define DDS_PWR_1K       2'h1
`define DDS_PWR_100K     2'h2
`define DDS_PWR_OPEN     2'h3
`define DDS_RB_DATA_LSB  4
`define DDS_CNT_MAX      5'h18
`define DDS_CHAIN_RST    1'h0
`define DDS_DAC_RST      16'h0000
`define DDS_PWR_RST      2'h0

`endif

// ===== dds_pkg.sv
`default_nettype none
`include "dds_consts.svh"

package dds_pkg;

    // ----------------------------------------------------------------
    // Shared types
    // ----------------------------------------------------------------
    typedef logic [`DDS_FRAME_BITS-1:0] dds_word_t;   // One serial frame
    typedef logic [15:0]                dds_code_t;   // One converter code

    // Core state, system clock domain
    typedef struct packed {
        logic                  sync_meta;   // Frame sync, first stage
        logic                  sync_s;      // Frame sync, synchronised
        logic                  sync_d;      // Frame sync, delayed
        logic                  ld_meta;     // Load strobe, first stage
        logic                  ld_s;        // Load strobe, synchronised
        logic                  ld_d;        // Load strobe, delayed
        logic                  chain_en;    // Chained operation selected
        logic                  rb_active;   // Readback word being shifted
        dds_word_t             rb_word;     // Readback word
        logic [1:0][1:0]       pwr;         // Power mode per channel
        logic [1:0][15:0]      in_reg;      // Input registers
        logic [1:0][15:0]      dac_reg;     // DAC registers
    } dds_core_t;

    // Receive state, link clock falling edge
    typedef struct packed {
        dds_word_t shreg;                   // Input shift register
    } dds_rx_t;

    // Transmit state, link clock rising edge
    typedef struct packed {
        logic [4:0] cnt;                    // Bits of this frame so far
        logic       chain_bit;              // Bit beyond the shift register
    } dds_tx_t;

endpackage

`default_nettype wire

// ===== dds_link_if.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Link between core, receiver and transmitter
// ----------------------------------------------------------------
interface dds_link_if;
    import dds_pkg::*;
    dds_word_t frame_word;   // Receiver shift register contents
    dds_word_t rb_word;      // Readback word from the core
    logic      rb_active;    // Readback in progress
    logic      chain_en;     // Chained operation

    modport rx_mp   (output frame_word);
    modport tx_mp   (input frame_word, input rb_word, input rb_active, input chain_en);
    modport core_mp (input frame_word, output rb_word, output rb_active, output chain_en);
endinterface

`default_nettype wire

// ===== dds_link_rx.sv
`timescale 1ns/1ps
`default_nettype none

module dds_link_rx
    import dds_pkg::*;
(
    input  wire logic   sclk_in,          // Link serial clock
    input  wire logic   rst_n_in,         // Asynchronous reset, active low
    input  wire logic   frame_sync_n_in,  // Frame sync, active low
    input  wire logic   serial_in_in,     // Serial data in
    dds_link_if.rx_mp   lnk               // Frame word toward the core
);

    dds_rx_t st_r;     // Registered state
    dds_rx_t st_nxt;   // Next state

    // ----------------------------------------------------------------
    // Shift on falling edges, only inside a frame
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (!frame_sync_n_in) begin
            // MSB enters first and walks up
            st_nxt.shreg = {st_r.shreg[`DDS_FRAME_BITS-2:0], serial_in_in};
        end
        // With sync high the word is held and clocks are ignored
    end

    always_ff @(negedge sclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Word stays still while sync is high, so the core may read it then
    assign lnk.frame_word = st_r.shreg;

endmodule

`default_nettype wire

// ===== dds_link_tx.sv
`timescale 1ns/1ps
`default_nettype none

module dds_link_tx
    import dds_pkg::*;
(
    input  wire logic   sclk_in,          // Link serial clock
    input  wire logic   rst_n_in,         // Asynchronous reset, active low
    input  wire logic   frame_sync_n_in,  // Frame sync, active low
    dds_link_if.tx_mp   lnk,              // Words and modes from core and receiver
    output logic        serial_out_out    // Serial data out
);

    dds_tx_t   st_r;     // Registered state
    dds_tx_t   st_nxt;   // Next state
    logic      clr;      // Idle between frames or in reset
    dds_word_t rb_shift; // Readback word advanced by the bit count

    // Counter and chain bit restart for every frame
    assign clr = frame_sync_n_in | ~rst_n_in;

    // ----------------------------------------------------------------
    // Rising edge: advance count, take bit beyond the register
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (st_r.cnt != `DDS_CNT_MAX) begin
            st_nxt.cnt = st_r.cnt + 5'h01;
        end
        // Oldest bit leaves on the rising edge
        st_nxt.chain_bit = lnk.frame_word[`DDS_FRAME_BITS-1];
    end

    always_ff @(posedge sclk_in or posedge clr) begin
        if (clr) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Output select: readback word in order, else chain data
    // ----------------------------------------------------------------
    // Readback bit is current before the first falling edge
    assign rb_shift = lnk.rb_word << st_r.cnt;

    always_comb begin
        if (lnk.rb_active) begin
            serial_out_out = rb_shift[`DDS_FRAME_BITS-1];
        end else if (lnk.chain_en) begin
            serial_out_out = st_r.chain_bit;
        end else begin
            // Standalone and no readback: line held low
            serial_out_out = 1'b0;
        end
    end

endmodule

`default_nettype wire

// ===== dds_serial_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module dds_serial_ctrl
    import dds_pkg::*;
(
    input  wire logic        clk_in,              // System clock, 100 MHz
    input  wire logic        rst_n_in,            // Asynchronous reset, active low
    input  wire logic        sclk_in,             // Link serial clock
    input  wire logic        frame_sync_n_in,     // Frame sync, active low
    input  wire logic        serial_in_in,        // Serial data in
    input  wire logic        load_strobe_n_in,    // Load strobe, active low
    output logic             serial_out_out,      // Serial data out
    output logic             serial_out_oe_out,   // Serial output enable
    output logic [15:0]      dac_a_out,           // Channel A DAC register
    output logic [15:0]      dac_b_out,           // Channel B DAC register
    output logic             chain_enable_bit_out,// Chained operation selected
    output logic             chan_a_sleep_hi_out, // Channel A mode, high bit
    output logic             chan_a_sleep_lo_out, // Channel A mode, low bit
    output logic             chan_b_sleep_hi_out, // Channel B mode, high bit
    output logic             chan_b_sleep_lo_out, // Channel B mode, low bit
    output logic [1:0]       amp_connect_out,     // Amplifier drives pin, [1]=B
    output logic [1:0]       term_1k_out,         // 1k to ground, [1]=B
    output logic [1:0]       term_100k_out,       // 100k to ground, [1]=B
    output logic [1:0]       term_open_out        // Pin left open, [1]=B
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    dds_core_t   st_r;        // Registered core state
    dds_core_t   st_nxt;      // Next core state
    dds_link_if  lnk ();      // Link between core and serial logic

    logic        frame_end;   // Sync has risen, frame complete
    logic        ld_fall;     // Load strobe falling edge
    logic [3:0]  cmd;         // Command field of the held frame
    logic [1:0]  sel;         // Channel selects, [1]=B, [0]=A
    dds_code_t   data;        // Data word of the held frame
    logic        rb_is_b;     // Readback selects channel B

    // ----------------------------------------------------------------
    // Serial side, link clock domain
    // ----------------------------------------------------------------
    dds_link_rx u_rx (
        .sclk_in         (sclk_in),
        .rst_n_in        (rst_n_in),
        .frame_sync_n_in (frame_sync_n_in),
        .serial_in_in    (serial_in_in),
        .lnk             (lnk.rx_mp)
    );

    dds_link_tx u_tx (
        .sclk_in         (sclk_in),
        .rst_n_in        (rst_n_in),
        .frame_sync_n_in (frame_sync_n_in),
        .lnk             (lnk.tx_mp),
        .serial_out_out  (serial_out_out)
    );

    // Changed between frames only, so the link side sees stable levels;
    // the link clock may be stopped then and cannot run a synchroniser
    assign lnk.rb_word   = st_r.rb_word;
    assign lnk.rb_active = st_r.rb_active;
    assign lnk.chain_en  = st_r.chain_en;

    // ----------------------------------------------------------------
    // Frame field split and edge detection
    // ----------------------------------------------------------------
    // Frame word is still once sync is high, read on the synced rise
    assign frame_end = st_r.sync_s & ~st_r.sync_d;
    // Strobe edge taken after the two-stage synchroniser
    assign ld_fall   = st_r.ld_d & ~st_r.ld_s;
    assign cmd       = lnk.frame_word[`DDS_CMD_MSB:`DDS_CMD_LSB];
    assign sel       = {lnk.frame_word[`DDS_SEL_B_POS],
                        lnk.frame_word[`DDS_SEL_A_POS]};
    assign data      = lnk.frame_word[`DDS_DATA_MSB:0];
    // Only B alone picks B; both or neither fall back to A
    assign rb_is_b   = sel[1] & ~sel[0];

    // ----------------------------------------------------------------
    // Core next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;

        // Two-stage synchronisers for the pins
        st_nxt.sync_meta = frame_sync_n_in;
        st_nxt.sync_s    = st_r.sync_meta;
        st_nxt.sync_d    = st_r.sync_s;
        st_nxt.ld_meta   = load_strobe_n_in;
        st_nxt.ld_s      = st_r.ld_meta;
        st_nxt.ld_d      = st_r.ld_s;

        // Strobe falling edge copies every input register
        if (ld_fall) begin
            st_nxt.dac_reg = st_r.in_reg;
        end

        // Whatever bits are held run, even after a short frame
        if (frame_end) begin
            // Readback lasts one frame, then output is released
            st_nxt.rb_active = 1'b0;
            case (cmd)
                `DDS_CMD_WRITE_IN: begin
                    for (int ch = 0; ch < 2; ch++) begin
                        if (sel[ch]) begin
                            st_nxt.in_reg[ch] = data;
                            // Strobe low makes the write transparent
                            if (!st_r.ld_s) begin
                                st_nxt.dac_reg[ch] = data;
                            end
                        end
                    end
                end
                `DDS_CMD_UPDATE: begin
                    for (int ch = 0; ch < 2; ch++) begin
                        if (sel[ch]) begin
                            st_nxt.dac_reg[ch] = st_r.in_reg[ch];
                        end
                    end
                end
                `DDS_CMD_WRITE_UPD: begin
                    for (int ch = 0; ch < 2; ch++) begin
                        if (sel[ch]) begin
                            st_nxt.in_reg[ch]  = data;
                            st_nxt.dac_reg[ch] = data;
                        end
                    end
                end
                `DDS_CMD_POWER: begin
                    // Bits 5..2 are filler; DAC contents untouched
                    st_nxt.pwr[1] = data[`DDS_PWR_B_LSB+1:`DDS_PWR_B_LSB];
                    st_nxt.pwr[0] = data[`DDS_PWR_A_LSB+1:`DDS_PWR_A_LSB];
                end
                `DDS_CMD_CHAIN: begin
                    st_nxt.chain_en = data[`DDS_CHAIN_POS];
                end
                `DDS_CMD_READBACK: begin
                    // Data bits ignored; word placed for next frame
                    st_nxt.rb_active = 1'b1;
                    st_nxt.rb_word   = '0;
                    st_nxt.rb_word[`DDS_RB_DATA_LSB+15:`DDS_RB_DATA_LSB] =
                        rb_is_b ? st_r.dac_reg[1] : st_r.dac_reg[0];
                end
                default: begin
                    // No-op and unsupported commands change nothing beyond the readback release above
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Core registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r           <= '0;
            st_r.sync_meta <= 1'b1;
            st_r.sync_s    <= 1'b1;
            st_r.sync_d    <= 1'b1;
            st_r.ld_meta   <= 1'b1;
            st_r.ld_s      <= 1'b1;
            st_r.ld_d      <= 1'b1;
            st_r.chain_en  <= `DDS_CHAIN_RST;
            st_r.pwr       <= {2{`DDS_PWR_RST}};
            st_r.in_reg    <= {2{`DDS_DAC_RST}};
            st_r.dac_reg   <= {2{`DDS_DAC_RST}};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Output driven in chained mode or during a readback
    assign serial_out_oe_out    = st_r.chain_en | st_r.rb_active;
    assign dac_a_out            = st_r.dac_reg[0];
    assign dac_b_out            = st_r.dac_reg[1];
    assign chain_enable_bit_out = st_r.chain_en;
    assign chan_a_sleep_hi_out  = st_r.pwr[0][1];
    assign chan_a_sleep_lo_out  = st_r.pwr[0][0];
    assign chan_b_sleep_hi_out  = st_r.pwr[1][1];
    assign chan_b_sleep_lo_out  = st_r.pwr[1][0];

    // Per-channel termination decode, straight from the mode flops
    for (genvar ch = 0; ch < 2; ch++) begin : g_term
        assign amp_connect_out[ch] = (st_r.pwr[ch] == `DDS_PWR_NORMAL);
        assign term_1k_out[ch]     = (st_r.pwr[ch] == `DDS_PWR_1K);
        assign term_100k_out[ch]   = (st_r.pwr[ch] == `DDS_PWR_100K);
        assign term_open_out[ch]   = (st_r.pwr[ch] == `DDS_PWR_OPEN);
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // Checks run on the core clock; the implications look one edge after the
    // executing edge, when the registered outputs have settled
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    chk_chain_enable_write: assert property (
        frame_end && cmd == `DDS_CMD_CHAIN |=> chain_enable_bit_out == $past(data[`DDS_CHAIN_POS]))
        else $error("chain enable not taken from data bit 0");

    chk_readback_default_a: assert property (
        frame_end && cmd == `DDS_CMD_READBACK && sel != 2'h2
        |=> st_r.rb_word[`DDS_RB_DATA_LSB+15:`DDS_RB_DATA_LSB] == $past(dac_a_out))
        else $error("readback did not select channel A");

    chk_readback_enable: assert property (
        frame_end && cmd == `DDS_CMD_READBACK |=> serial_out_oe_out && st_r.rb_active)
        else $error("readback did not enable serial output");

    chk_readback_release: assert property (
        st_r.rb_active && frame_end && cmd != `DDS_CMD_READBACK && !st_r.chain_en
        |=> !st_r.rb_active && serial_out_oe_out == chain_enable_bit_out)
        else $error("serial output held after readback frame");

    chk_power_load: assert property (
        frame_end && cmd == `DDS_CMD_POWER
        |=> {chan_b_sleep_hi_out, chan_b_sleep_lo_out} == $past(data[7:6])
            && {chan_a_sleep_hi_out, chan_a_sleep_lo_out} == $past(data[1:0]))
        else $error("power modes not loaded from bits 7:6 and 1:0");

    chk_term_onehot: assert property (
        $onehot({amp_connect_out[0], term_1k_out[0], term_100k_out[0], term_open_out[0]})
        && (term_open_out[1] == (chan_b_sleep_hi_out && chan_b_sleep_lo_out)))
        else $error("termination decode wrong");

    chk_power_keeps_dac: assert property (
        frame_end && cmd == `DDS_CMD_POWER && !ld_fall |=> $stable(dac_a_out) && $stable(dac_b_out))
        else $error("DAC register changed by power command");

    chk_immediate_update: assert property (
        frame_end && cmd == `DDS_CMD_WRITE_IN && sel[0] && !st_r.ld_s
        |=> dac_a_out == $past(data) ##1 dac_a_out == $past(data, 2) || ld_fall || frame_end)
        else $error("transparent write did not reach DAC register");

    chk_deferred_hold: assert property (
        frame_end && cmd == `DDS_CMD_WRITE_IN && st_r.ld_s && !ld_fall |=> $stable(dac_a_out))
        else $error("deferred write reached DAC register early");

    chk_strobe_copy: assert property (
        ld_fall && !frame_end |=> dac_a_out == $past(st_r.in_reg[0]) && dac_b_out == $past(st_r.in_reg[1]))
        else $error("strobe fall did not copy input registers");

    chk_readback_pick_b: assert property (
        frame_end && cmd == `DDS_CMD_READBACK && sel == 2'h2
        |=> st_r.rb_word[`DDS_RB_DATA_LSB+15:`DDS_RB_DATA_LSB] == $past(dac_b_out))
        else $error("readback did not select channel B");

    chk_update_from_input: assert property (
        frame_end && cmd == `DDS_CMD_UPDATE && sel[0]
        |=> dac_a_out == $past(st_r.in_reg[0]))
        else $error("update command did not copy input register");

    chk_write_update: assert property (
        frame_end && cmd == `DDS_CMD_WRITE_UPD && sel[1]
        |=> dac_b_out == $past(data))
        else $error("write and update did not reach DAC register");

    chk_noop_holds: assert property (
        frame_end && cmd == 4'h0 && !ld_fall
        |=> $stable(dac_a_out) && $stable(dac_b_out) && $stable(chain_enable_bit_out))
        else $error("no-op frame changed state");

    cov_readback_b: cover property (frame_end && cmd == `DDS_CMD_READBACK && sel == 2'h2);
    cov_chain_on: cover property (frame_end && cmd == `DDS_CMD_CHAIN && data[`DDS_CHAIN_POS]);
    cov_deferred: cover property (frame_end && cmd == `DDS_CMD_WRITE_IN && st_r.ld_s ##[1:200] ld_fall);
    cov_power_open: cover property (term_open_out[0] && term_open_out[1]);
    cov_update_cmd: cover property (frame_end && cmd == `DDS_CMD_UPDATE && sel[0]);

endmodule

`default_nettype wire

// ===== dds_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Host side of the link; the link clock runs only inside frames
// ----------------------------------------------------------------
module dds_host_model (
    output logic      sclk_out,    // Link clock, idle high
    output logic      sync_n_out,  // Frame sync, active low
    output logic      mosi_out,    // Serial data toward the device
    input  wire logic miso_in      // Serial data from the device
);
    logic [47:0] rx;               // Bits seen on the return line

    // Idle levels at time zero
    initial begin
        sclk_out   = 1'b1;
        sync_n_out = 1'b1;
        mosi_out   = 1'b0;
        rx         = '0;
    end

    // One gated burst of n bits, MSB first, then sync rises
    task automatic xfer(input logic [47:0] w, input int n);
        sync_n_out = 1'b0;
        #20;
        for (int i = n - 1; i >= 0; i--) begin
            mosi_out = w[i];
            #32 sclk_out = 1'b0;
            rx = {rx[46:0], miso_in};
            #32 sclk_out = 1'b1;
        end
        #20 sync_n_out = 1'b1;
        mosi_out = ~mosi_out; // Released line does not hold its value
        #100;
    endtask
endmodule

`default_nettype wire

// ===== test_dual_dac_serial_control.sv
`timescale 1ns/1ps
`default_nettype none

module test_dual_dac_serial_control;
    import dds_pkg::*;
    logic             clk_in, rst_n_in, ld_n;   // Core clock, reset, strobe
    wire logic        sclk, sync_n, mosi, miso; // Link wires
    wire logic        oe, chain;                // Output enable, chain mode
    wire logic        a_hi, a_lo, b_hi, b_lo;   // Power mode bits
    wire logic [1:0]  amp, t1k, t100k, topen;   // Output stage decode
    wire logic [15:0] dac_a, dac_b;             // DAC registers
    int               miscompares, n_tests, cyc; // Counters
    logic [31:0]      seed, d, va, vb;          // Random source, models
    logic [35:0]      q[$];                     // Expected results
    logic [35:0]      e;                        // Oldest note
    event             look;                     // Results ready

    dds_serial_ctrl dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk),
        .frame_sync_n_in(sync_n), .serial_in_in(mosi), .load_strobe_n_in(ld_n),
        .serial_out_out(miso), .serial_out_oe_out(oe), .dac_a_out(dac_a), .dac_b_out(dac_b),
        .chain_enable_bit_out(chain), .chan_a_sleep_hi_out(a_hi), .chan_a_sleep_lo_out(a_lo),
        .chan_b_sleep_hi_out(b_hi), .chan_b_sleep_lo_out(b_lo), .amp_connect_out(amp),
        .term_1k_out(t1k), .term_100k_out(t100k), .term_open_out(topen));
    dds_host_model h (.sclk_out(sclk), .sync_n_out(sync_n), .mosi_out(mosi), .miso_in(miso));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    always #5 clk_in = ~clk_in;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Picks the observed value for a note code
    function automatic logic [31:0] obs(input logic [3:0] c);
        case (c)
            4'h0: return {16'h0000, dac_a};
            4'h1: return {16'h0000, dac_b};
            4'h2: return {20'h00000, b_hi, b_lo, a_hi, a_lo, amp, t1k, t100k, topen};
            4'h3: return {31'h0, oe};
            4'h4: return {16'h0000, h.rx[19:4]};
            4'h6: return {8'h00, h.rx[23:0]};
            default: return {31'h0, chain};
        endcase
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want) begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic note(input logic [3:0] c, input logic [31:0] v);
        q.push_back({c, v});
        -> look;
    endtask

    // Watcher takes every queued note, oldest first, and compares it
    always @(look) begin
        #1;
        while (q.size() > 0) begin
            e = q.pop_front();
            check(obs(e[35:32]), e[31:0]);
        end
    end

    task automatic frame(input logic [47:0] w, input int n);
        h.xfer(w, n);
        repeat (6) @(negedge clk_in);
    endtask

    task automatic pwr(input logic [1:0] m, input logic [1:0] n);
        frame({24'h0, 4'h4, 4'h0, 8'h00, m, 4'hF, n}, 24);
        note(4'h2, {20'h0, m, n, m == 2'h0, n == 2'h0, m == 2'h1, n == 2'h1,
              m == 2'h2, n == 2'h2, m == 2'h3, n == 2'h3});
    endtask

    // Request, then a no-op frame clocks the register out
    task automatic rb(input logic [3:0] s, input logic [15:0] v);
        frame({24'h0, 4'h9, s, 16'hFFFF}, 24);
        note(4'h3, 32'h1);
        frame(48'h0, 24);
        note(4'h4, {16'h0, v});
        note(4'h3, 32'h0);
    endtask

    // Hang guard
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 50000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        rst_n_in = 1'b0;
        ld_n = 1'b0;
        seed = 32'h60;
        {miscompares, n_tests, cyc} = '0;
        repeat (20) @(negedge clk_in);
        rst_n_in = 1'b1;
        repeat (5) @(negedge clk_in);
        note(4'h0, 32'h0);
        note(4'h5, 32'h0);
        note(4'h2, 32'h0C0);
        note(4'h3, 32'h0);
        va = rnd() & 32'hFFFF;
        frame({24'h0, 4'h1, 4'h1, va[15:0]}, 24);
        note(4'h0, va);
        ld_n = 1'b1;
        vb = rnd() & 32'hFFFF;
        frame({24'h0, 4'h1, 4'h8, vb[15:0]}, 24);
        note(4'h1, 32'h0);
        ld_n = 1'b0;
        repeat (6) @(negedge clk_in);
        note(4'h1, vb);
        va = rnd() & 32'hFFFF;
        vb = va;
        frame({24'h0, 4'h3, 4'h9, va[15:0]}, 24);
        note(4'h0, va);
        note(4'h1, vb);
        for (int k = 0; k < 4; k++) pwr(k[1:0], 2'h3 - k[1:0]);
        note(4'h1, vb);
        vb = rnd() & 32'hFFFF;
        frame({24'h0, 4'h3, 4'h8, vb[15:0]}, 24);
        note(4'h1, vb);
        rb(4'h1, va[15:0]);
        rb(4'h8, vb[15:0]);
        rb(4'h9, va[15:0]);
        rb(4'h0, va[15:0]);
        frame(48'h800001, 24);
        note(4'h5, 32'h1);
        note(4'h3, 32'h1);
        d = rnd();
        frame({8'h31, d[15:0], 8'h38, vb[15:0] ^ 16'h5A5A}, 48);
        note(4'h6, {8'h00, 8'h31, d[15:0]});
        note(4'h0, va);
        note(4'h1, vb ^ 32'h5A5A);
        frame(48'h800000, 24);
        note(4'h5, 32'h0);
        note(4'h3, 32'h0);
        // Deferred write, then the update command moves it across
        ld_n = 1'b1;
        frame({24'h0, 4'h1, 4'h1, d[31:16]}, 24);
        note(4'h0, va);
        frame({24'h0, 4'h2, 4'h1, 16'h0000}, 24);
        note(4'h0, {16'h0, d[31:16]});
        // 28 clocks: the last 24 bits held are executed
        frame({20'h0, 4'h5, 4'h3, 4'h1, ~d[31:16]}, 28);
        note(4'h0, {16'h0, ~d[31:16]});
        repeat (4) @(negedge clk_in);
        tally_and_finish();
    end
endmodule

`default_nettype wire
